// ---- rtl/spi_master_slave.sv ----
// Purpose: Serial peripheral port acting as master or slave.
// Assumes: ref_clk at 100 MHz; pins asynchronous; mode 0 style phase with
//          programmable clock idle level.
// Notes:   The asynchronous deep-sleep wake path is a combinational select
//          level request kept outside flip-flops by design.
`timescale 1ns/1ps
module spi_master_slave
    import spi_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              enable,
    input  wire logic              masterMode,
    input  wire logic              clkIdleHigh,
    input  wire logic              selActiveHigh,
    input  wire logic [DIV_W-1:0]  halfDiv,
    input  wire logic [IEN_W-1:0]  intEnableSet,
    input  wire logic [IEN_W-1:0]  intEnableClr,
    input  wire logic              txValid,
    input  wire logic [W-1:0]      txData,
    input  wire logic [LEN_W-1:0]  txLenM1,
    input  wire logic              txEndOfTransfer,
    input  wire logic              txIgnoreRx,
    output logic                   txReady,
    input  wire logic              rxRead,
    output logic                   rxValid,
    output logic [W-1:0]           rxData,
    output logic                   rxOverrun,
    input  wire logic              overrunClr,
    input  wire logic              selChangeClr,
    output logic                   selChanged,
    output logic                   busy,
    output logic                   irq,
    output logic                   wakeReq,
    input  wire logic              sckIn,
    output logic                   sckOut,
    output logic                   sckOe,
    input  wire logic              mosiIn,
    output logic                   mosiOut,
    output logic                   mosiOe,
    input  wire logic              misoIn,
    output logic                   misoOut,
    output logic                   misoOe,
    input  wire logic              selIn,
    output logic                   selOut,
    output logic                   selOe
);
    typedef enum logic [1:0] {M_IDLE, M_LOW, M_HIGH, M_DONE} mstate_e;

    mstate_e           st_q;
    mstate_e           st_d;
    logic [DIV_W-1:0]  divCnt_q;
    logic [LEN_W-1:0]  bitCnt_q;
    logic [LEN_W-1:0]  lenM1_q;
    logic              eot_q;
    logic              ignRx_q;
    logic              selAsserted_q;
    logic              sckLvl_q;
    logic [IEN_W-1:0]  ien_q;
    logic              rxValid_q;
    logic              ovr_q;
    logic              selChg_q;
    logic [W-1:0]      rxData_q;
    logic              txReady_q;
    logic              irq_q;
    logic              sckOut_q;
    logic              sckOe_q;
    logic              mosiOut_q;
    logic              mosiOe_q;
    logic              misoOut_q;
    logic              misoOe_q;
    logic              selOut_q;
    logic              selOe_q;
    logic              sckS;
    logic              selS;
    logic              mosiS;
    logic              misoS;
    logic              sckPrev_q;
    logic              selPrev_q;

    // Pin inputs pass two flip-flops before any logic reads them, except selIn for the wake request.
    spi_sync2 uSyncSck (.clk(ref_clk), .rst(rst), .d(sckIn), .q(sckS));
    spi_sync2 uSyncSel (.clk(ref_clk), .rst(rst), .d(selIn), .q(selS));
    spi_sync2 uSyncMosi (.clk(ref_clk), .rst(rst), .d(mosiIn), .q(mosiS));
    spi_sync2 uSyncMiso (.clk(ref_clk), .rst(rst), .d(misoIn), .q(misoS));

    // Decoding of link events.
    wire tick      = (divCnt_q == '0);
    wire isMaster  = masterMode;
    wire slvActive = enable && !masterMode;
    wire selLvlAct = selActiveHigh ? selS : !selS;
    wire slvSel    = slvActive && selLvlAct;
    wire sckNorm   = clkIdleHigh ? !sckS : sckS;
    wire sckPrevN  = clkIdleHigh ? !sckPrev_q : sckPrev_q;
    wire slvLead   = slvSel && sckNorm && !sckPrevN;
    wire slvTrail  = slvSel && !sckNorm && sckPrevN;
    wire selEdge   = slvActive && (selS != selPrev_q);
    wire mStart    = isMaster && enable && txValid && (st_q == M_IDLE);
    wire mLead     = (st_q == M_LOW) && tick;
    wire mTrail    = (st_q == M_HIGH) && tick;
    wire mLastBit  = (bitCnt_q == lenM1_q);
    wire mFrameEnd = mTrail && mLastBit;
    wire sLastBit  = (bitCnt_q == lenM1_q);
    wire sFrameEnd = slvLead && sLastBit;
    wire sLoad     = slvSel && txValid && txReady_q && (bitCnt_q == '0)
                     && !slvLead;
    wire anyLoad   = mStart || sLoad;
    wire sampleEn  = mLead || slvLead;
    wire shiftEn   = (mTrail && !mLastBit) || slvTrail;
    wire sampleBit = isMaster ? misoS : mosiS;
    wire frameEnd  = mFrameEnd || sFrameEnd;
    wire rxStore   = frameEnd && !ignRx_q;
    wire ovrEv     = rxStore && rxValid_q && !rxRead;
    wire txBit;
    wire [W-1:0] rxWord;
    wire [W-1:0] rxFull = mFrameEnd ? rxWord : {rxWord[W-2:0], sampleBit};
    wire selDrvAct = selActiveHigh;
    wire evSet     = (selChg_q && ien_q[IEN_SSEL])
                     || (rxValid_q && ien_q[IEN_RXRDY])
                     || (ovr_q && ien_q[IEN_OVR]);

    spi_shifter #(.W(W)) uShift (
        .clk       (ref_clk),
        .rst       (rst),
        .load      (anyLoad),
        .loadData  (txData),
        .lenM1     (lenM1_q),
        .sampleEn  (sampleEn),
        .sampleBit (sampleBit),
        .shiftEn   (shiftEn),
        .outBit    (txBit),
        .rxWord    (rxWord)
    );

    always_comb begin
        st_d = st_q;
        case (st_q)
            M_IDLE: begin
                if (mStart) begin
                    st_d = M_LOW;
                end
            end
            M_LOW: begin
                if (tick) begin
                    st_d = M_HIGH;
                end
            end
            M_HIGH: begin
                if (mFrameEnd) begin
                    st_d = M_DONE;
                end else if (tick) begin
                    st_d = M_LOW;
                end
            end
            M_DONE: begin
                if (tick) begin
                    st_d = M_IDLE;
                end
            end
            default: begin
                st_d = M_IDLE;
            end
        endcase
    end

    // Master sequencer; a cleared enable or slave mode forces it idle.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= M_IDLE;
        end else if (!enable || !isMaster) begin
            st_q <= M_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            divCnt_q <= HALF_DIV_RST;
        end else if (st_q == M_IDLE || tick) begin
            divCnt_q <= halfDiv;
        end else begin
            divCnt_q <= divCnt_q - 1'b1;
        end
    end

    // Bit counter is shared; frames are 1 to 16 bits long.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bitCnt_q <= '0;
        end else if (!enable || (slvActive && !slvSel)) begin
            bitCnt_q <= '0;
        end else if (mStart || frameEnd) begin
            bitCnt_q <= '0;
        end else if (mTrail || slvLead) begin
            bitCnt_q <= bitCnt_q + 1'b1;
        end
    end

    // Per-frame control captured with the transmit word.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            lenM1_q <= '1;
            eot_q   <= 1'b1;
            ignRx_q <= 1'b0;
        end else if (anyLoad) begin
            lenM1_q <= txLenM1;
            eot_q   <= txEndOfTransfer;
            ignRx_q <= txIgnoreRx;
        end
    end

    // Select stays asserted between frames until end of transfer.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            selAsserted_q <= 1'b0;
        end else if (!enable || !isMaster) begin
            selAsserted_q <= 1'b0;
        end else if (mStart) begin
            selAsserted_q <= 1'b1;
        end else if (st_q == M_DONE && tick && eot_q) begin
            selAsserted_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sckLvl_q <= 1'b0;
        end else if (mLead) begin
            sckLvl_q <= 1'b1;
        end else if (mTrail || st_q == M_IDLE) begin
            sckLvl_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sckPrev_q <= 1'b0;
            selPrev_q <= 1'b1;
        end else begin
            sckPrev_q <= sckS;
            selPrev_q <= selS;
        end
    end

    // Transmit holding is free when enabled with the master idle, or with the slave selected at bit count zero.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            txReady_q <= 1'b0;
        end else if (!enable) begin
            txReady_q <= 1'b0;
        end else if (anyLoad) begin
            txReady_q <= 1'b0;
        end else begin
            txReady_q <= isMaster ? (st_q == M_IDLE) : slvSel && bitCnt_q == '0;
        end
    end

    // Status flags: a hardware set wins over a same-cycle clear.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rxValid_q <= 1'b0;
            rxData_q  <= '0;
            ovr_q     <= 1'b0;
            selChg_q  <= 1'b0;
        end else if (!enable) begin
            rxValid_q <= 1'b0;
            ovr_q     <= 1'b0;
            selChg_q  <= 1'b0;
        end else begin
            if (rxStore) begin
                rxValid_q <= 1'b1;
                rxData_q  <= rxFull;
            end else if (rxRead) begin
                rxValid_q <= 1'b0;
            end
            if (ovrEv) begin
                ovr_q <= 1'b1;
            end else if (overrunClr) begin
                ovr_q <= 1'b0;
            end
            if (selEdge) begin
                selChg_q <= 1'b1;
            end else if (selChangeClr) begin
                selChg_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ien_q <= '0;
        end else begin
            ien_q <= (ien_q | intEnableSet) & ~intEnableClr;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= evSet;
        end
    end

    // Pin drivers; master-mode pins are driven regardless of enable.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sckOut_q  <= 1'b0;
            sckOe_q   <= 1'b0;
            mosiOut_q <= 1'b0;
            mosiOe_q  <= 1'b0;
            selOut_q  <= 1'b1;
            selOe_q   <= 1'b0;
            misoOut_q <= 1'b0;
            misoOe_q  <= 1'b0;
        end else begin
            sckOe_q   <= masterMode;
            mosiOe_q  <= masterMode;
            selOe_q   <= masterMode;
            sckOut_q  <= sckLvl_q ^ clkIdleHigh;
            mosiOut_q <= selAsserted_q && txBit;
            selOut_q  <= selAsserted_q ? selDrvAct : !selDrvAct;
            misoOe_q  <= slvSel;
            misoOut_q <= txBit;
        end
    end

    assign txReady   = txReady_q;
    assign rxValid   = rxValid_q;
    assign rxData    = rxData_q;
    assign rxOverrun = ovr_q;
    assign selChanged = selChg_q;
    assign busy      = (st_q != M_IDLE) || (bitCnt_q != '0);
    assign irq       = irq_q;
    assign sckOut    = sckOut_q;
    assign sckOe     = sckOe_q;
    assign mosiOut   = mosiOut_q;
    assign mosiOe    = mosiOe_q;
    assign misoOut   = misoOut_q;
    assign misoOe    = misoOe_q;
    assign selOut    = selOut_q;
    assign selOe     = selOe_q;

    // Clockless wake request: select asserted with slave mode and its
    // enable set; a limitation is that only select activity is seen.
    assign wakeReq = slvActive && ien_q[IEN_SSEL]
                     && (selActiveHigh ? selIn : !selIn);
endmodule

// ---- rtl/spi_pkg.sv ----
// Purpose: Shared constants for the serial peripheral block.
// Assumes: One clock, ref_clk at 100 MHz; control bits are plain ports.
// Notes:   Frame length field holds length minus one.
// How it works
// - Frames of 1 to 16 bits move in hardware; longer ones by software.
// - A mode input selects master or slave operation.
// - Transmit proceeds even when received data is never read.
// - Control bits travel with each transmit word per frame.
// - One slave-select line, input or output, with selectable polarity.
// - Master drives serial clock; it toggles only during a transfer.
// - Serial clock idle level is programmable.
// - In master mode clock, master-out and select are driven even disabled.
// - Master drives master-out; slave samples it.
// - Master samples slave-out; slave drives it.
// - Slave-out driven only when enabled, slave mode, and selected.
// - Master asserts select before first bit, releases it after the last.
// - Select is active low after reset, optionally active high.
// - Slave is addressed while select is active; master must assert it.
// - Slave raises its wake request from select activity even without a clock.
// - An event wakes the part only if its enable bit is set.
// - With the clock running, wake-up works in master or slave mode.
// - Wake events: select change, receive data ready, receive overrun.
// - Clearing enable resets the state machine and counters.
// - Slave mode: clock, master-out, select inputs; slave-out output.
package spi_pkg;
    localparam int          DATA_W       = 16;
    localparam int          LEN_W        = 4;
    localparam int          DIV_W        = 8;
    localparam logic [7:0]  HALF_DIV_RST = 8'h04;
    localparam int          IEN_W        = 3;
    localparam int          IEN_SSEL     = 0;
    localparam int          IEN_RXRDY    = 1;
    localparam int          IEN_OVR      = 2;
    localparam logic        SSEL_POL_RST = 1'b0;
endpackage

// ---- rtl/spi_sync2.sv ----
// Purpose: Two flip-flop synchroniser for a single level.
// Assumes: Input is asynchronous to clk.
// Notes:   The first stage feeds only the second.
`timescale 1ns/1ps
module spi_sync2 (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ---- rtl/spi_shifter.sv ----
// Purpose: Frame shift register shared by master and slave modes.
// Assumes: Shift and sample strobes are one-cycle pulses from the caller.
// Notes:   Data is MSB first within the active frame length.
`timescale 1ns/1ps
module spi_shifter
    import spi_pkg::*;
#(
    parameter int W = DATA_W
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 load,
    input  wire logic [W-1:0]         loadData,
    input  wire logic [LEN_W-1:0]     lenM1,
    input  wire logic                 sampleEn,
    input  wire logic                 sampleBit,
    input  wire logic                 shiftEn,
    output logic                      outBit,
    output logic [W-1:0]              rxWord
);
    logic [W-1:0] tx_q;
    logic [W-1:0] tx_d;
    logic [W-1:0] rx_q;

    // The transmit bit for an n-bit frame sits at position n-1.
    assign outBit = tx_q[lenM1];
    assign tx_d   = {tx_q[W-2:0], 1'b0};
    assign rxWord = rx_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_q <= '0;
        end else if (load) begin
            tx_q <= loadData;
        end else if (shiftEn) begin
            tx_q <= tx_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_q <= '0;
        end else if (load) begin
            rx_q <= '0;
        end else if (sampleEn) begin
            rx_q <= {rx_q[W-2:0], sampleBit};
        end
    end
endmodule

// ---- testbench/spi_master_slave_monitor.sv ----
// Purpose: Port checker for the serial peripheral block.
// Assumes: One ref_clk domain; rst asynchronous, active high.
// Notes:   Attached by bind; sees only the top module's ports.
`timescale 1ns/1ps
module spi_master_slave_monitor (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic masterMode,
    input wire logic clkIdleHigh,
    input wire logic selActiveHigh,
    input wire logic rxRead,
    input wire logic overrunClr,
    input wire logic busy,
    input wire logic rxValid,
    input wire logic rxOverrun,
    input wire logic selChanged,
    input wire logic irq,
    input wire logic wakeReq,
    input wire logic sckOut,
    input wire logic sckOe,
    input wire logic mosiOe,
    input wire logic misoOe,
    input wire logic selOut,
    input wire logic selOe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence settledMaster;
        masterMode && $past(masterMode) && !$past(rst);
    endsequence
    // Registered pins lag a setting change by one edge, so both are steady.
    sequence steadyIdle;
        $stable(clkIdleHigh) && $past(clkIdleHigh) == $past(clkIdleHigh, 2)
        && !$past(rst) && !$past(rst, 2);
    endsequence
    master_drive_a: assert property
        (settledMaster |-> sckOe && mosiOe && selOe)
        else $error("master pins not driven");
    slave_inputs_a: assert property
        (!masterMode && !$past(masterMode) && !$past(rst)
         |-> !sckOe && !mosiOe && !selOe)
        else $error("slave drives master pins");
    miso_gate_a: assert property
        (misoOe |-> $past(enable) && !$past(masterMode))
        else $error("miso driven outside enabled slave mode");
    sck_quiet_a: assert property
        (steadyIdle ##0 (masterMode && $past(masterMode) && $changed(sckOut))
         |-> busy || $past(busy))
        else $error("sck toggled outside a transfer");
    sck_idle_a: assert property
        (steadyIdle ##0 (settledMaster ##0 (!busy && !$past(busy)))
         |-> sckOut == clkIdleHigh)
        else $error("sck not at idle level");
    sel_framing_a: assert property
        (steadyIdle ##0 (masterMode && $changed(sckOut))
         |-> selOut == selActiveHigh)
        else $error("sck toggled with select inactive");
    quiet_irq_a: assert property
        (!rxValid && !rxOverrun && !selChanged
         && $past(!rxValid && !rxOverrun && !selChanged) |-> !irq)
        else $error("irq without a flag");
    rx_hold_a: assert property
        (rxValid && !rxRead && enable ##1 enable |-> rxValid)
        else $error("receive flag dropped unread");
    ovr_hold_a: assert property
        (rxOverrun && !overrunClr && enable ##1 enable |-> rxOverrun)
        else $error("overrun flag dropped uncleared");
    wake_slave_a: assert property
        (wakeReq |-> !masterMode)
        else $error("wake request in master mode");
endmodule
bind spi_master_slave spi_master_slave_monitor u_mon (
    .ref_clk(ref_clk), .rst(rst), .enable(enable), .masterMode(masterMode),
    .clkIdleHigh(clkIdleHigh), .selActiveHigh(selActiveHigh),
    .rxRead(rxRead), .overrunClr(overrunClr), .busy(busy),
    .rxValid(rxValid), .rxOverrun(rxOverrun), .selChanged(selChanged),
    .irq(irq), .wakeReq(wakeReq), .sckOut(sckOut), .sckOe(sckOe),
    .mosiOe(mosiOe), .misoOe(misoOe), .selOut(selOut), .selOe(selOe)
);

// ---- testbench/spi_far_device.sv ----
// Purpose: External serial device: slave to our master, master to our slave.
// Assumes: Mode 0 phase; the link clock stands still between frames.
// Notes:   Released lines show the inverse of their last value.
`timescale 1ns/1ps
module spi_far_device (
    input  wire logic        clkIdleHigh,
    input  wire logic        selActiveHigh,
    input  wire logic        sckLine,
    input  wire logic        selLine,
    input  wire logic        mosiLine,
    input  wire logic        misoLine,
    input  wire logic [4:0]  farLen,
    input  wire logic [15:0] farPat,
    output logic             farSck,
    output logic             farSel,
    output logic             farMosi,
    output logic             farMiso,
    output logic [15:0]      capWord
);
    logic driving = 1'b0;
    int   bitIdx  = 0;
    initial begin
        farMosi = 1'b0;
        farMiso = 1'b0;
        capWord = 16'h0000;
    end
    always @(clkIdleHigh or selActiveHigh) begin
        if (!driving) begin
            farSck = clkIdleHigh;
            farSel = ~selActiveHigh;
        end
    end
    always @(selLine) begin
        if (!driving && selLine === selActiveHigh) begin
            bitIdx = farLen - 1;
            farMiso = farPat[bitIdx];
            capWord = 16'h0000;
        end else if (!driving) begin
            farMiso = ~farMiso;
        end
    end
    always @(sckLine) begin
        if (!driving && selLine === selActiveHigh) begin
            if (sckLine !== clkIdleHigh) begin
                capWord = {capWord[14:0], mosiLine};
            end else begin
                bitIdx = (bitIdx == 0) ? farLen - 1 : bitIdx - 1;
                farMiso = farPat[bitIdx];
            end
        end
    end
    task automatic frame(input logic [15:0] w, input int n);
        int i;
        driving = 1'b1;
        capWord = 16'h0000;
        farSel = selActiveHigh;
        farMosi = w[n-1];
        for (i = n - 1; i >= 0; i--) begin
            #62.5 farSck = ~clkIdleHigh;
            capWord = {capWord[14:0], misoLine};
            #62.5 farSck = clkIdleHigh;
            if (i > 0) farMosi = w[i-1];
        end
        #62.5 farSel = ~selActiveHigh;
        farMosi = ~farMosi;
        driving = 1'b0;
    endtask
endmodule

// ---- testbench/spi_master_slave_tb_top.sv ----
// Purpose: Self-checking bench for the serial peripheral block.
// Assumes: Inputs change at the falling edge of ref_clk.
// Notes:   Slave transfers fork the word hand-over with the far frame.
`timescale 1ns/1ps
module spi_master_slave_tb_top import spi_pkg::*; ;
    logic ref_clk = 1'b0, rst = 1'b1, enable = 1'b0, masterMode = 1'b1;
    logic clkIdleHigh = 1'b0, selActiveHigh = 1'b0, txValid = 1'b0;
    logic txEndOfTransfer = 1'b1, txIgnoreRx = 1'b0, rxRead = 1'b0;
    logic [IEN_W-1:0] intEnableSet = 3'h0;
    logic [DATA_W-1:0] txData = 16'h0000;
    logic [LEN_W-1:0] txLenM1 = 4'h0;
    logic [4:0]  farLen = 5'h10;
    logic [15:0] capWord, rxData;
    logic txReady, rxValid, rxOverrun, selChanged, busy, irq, wakeReq;
    logic sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, selOut, selOe;
    logic farSck, farSel, farMosi, farMiso;
    int nErrors = 0, totalChecks = 0, k;
    logic [3:0]  cfgLm1 [3] = '{4'h0, 4'hF, 4'h7};
    logic [15:0] cfgWord [3] = '{16'h0001, 16'h5A3C, 16'h0096};
    logic [15:0] cfgRx [3] = '{16'h0001, 16'hC3A5, 16'h00A5};
    logic cfgIdle [3] = '{1'b0, 1'b1, 1'b0};
    logic cfgPol [3] = '{1'b0, 1'b1, 1'b1};
    wire logic sckLine = sckOe ? sckOut : farSck;
    wire logic mosiLine = mosiOe ? mosiOut : farMosi;
    wire logic misoLine = misoOe ? misoOut : farMiso;
    wire logic selLine = selOe ? selOut : farSel;
    always #5 ref_clk = ~ref_clk;
    spi_master_slave u_spi_master_slave (
        .ref_clk(ref_clk), .rst(rst), .enable(enable), .masterMode(masterMode),
        .clkIdleHigh(clkIdleHigh), .selActiveHigh(selActiveHigh),
        .halfDiv(HALF_DIV_RST), .intEnableSet(intEnableSet),
        .intEnableClr(3'h0), .txValid(txValid), .txData(txData),
        .txLenM1(txLenM1), .txEndOfTransfer(txEndOfTransfer),
        .txIgnoreRx(txIgnoreRx), .txReady(txReady), .rxRead(rxRead),
        .rxValid(rxValid), .rxData(rxData), .rxOverrun(rxOverrun),
        .overrunClr(1'b0), .selChangeClr(1'b0), .selChanged(selChanged),
        .busy(busy), .irq(irq), .wakeReq(wakeReq), .sckIn(sckLine),
        .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiLine), .mosiOut(mosiOut),
        .mosiOe(mosiOe), .misoIn(misoLine), .misoOut(misoOut),
        .misoOe(misoOe), .selIn(selLine), .selOut(selOut), .selOe(selOe)
    );
    spi_far_device u_far (
        .clkIdleHigh(clkIdleHigh), .selActiveHigh(selActiveHigh),
        .sckLine(sckLine), .selLine(selLine), .mosiLine(mosiLine),
        .misoLine(misoLine), .farLen(farLen), .farPat(16'hC3A5),
        .farSck(farSck), .farSel(farSel), .farMosi(farMosi),
        .farMiso(farMiso), .capWord(capWord)
    );
    task automatic finishTest();
        $display("checks %0d mismatches %0d", totalChecks, nErrors);
        if (nErrors == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        totalChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("unexpected at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkFlag(input logic got, input logic exp);
        chkWord({15'h0000, got}, {15'h0000, exp});
    endtask
    // Every wait is bounded; running out counts as a mismatch and ends.
    task automatic waitFor(input int which);
        int i;
        for (i = 0; i < 4000; i++) begin
            @(negedge ref_clk);
            if (which == 0 && rxValid === 1'b1) break;
            if (which == 1 && busy === 1'b0 && txReady === 1'b1) break;
            if (which == 2 && selOut === ~selActiveHigh) break;
            if (which == 3 && txReady === 1'b1) break;
        end
        if (i == 4000) begin
            nErrors++;
            finishTest();
        end
    endtask
    task automatic send(input logic [15:0] d, input logic [3:0] lm1,
                        input logic eot, input logic ign);
        waitFor(3);
        txData = d;
        txLenM1 = lm1;
        txEndOfTransfer = eot;
        txIgnoreRx = ign;
        txValid = 1'b1;
        @(negedge ref_clk);
        txValid = 1'b0;
    endtask
    task automatic readRx();
        @(negedge ref_clk);
        rxRead = 1'b1;
        @(negedge ref_clk);
        rxRead = 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge ref_clk);
        rst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chkWord({11'h000, sckOe, mosiOe, selOe, misoOe, selOut}, 16'h001D);
        $display("test pins after reset done");
        enable = 1'b1;
        intEnableSet = 3'h7;
        @(negedge ref_clk);
        intEnableSet = 3'h0;
        for (k = 0; k < 3; k++) begin
            clkIdleHigh = cfgIdle[k];
            selActiveHigh = cfgPol[k];
            farLen = {1'b0, cfgLm1[k]} + 5'h01;
            repeat (4) @(negedge ref_clk);
            send(cfgWord[k], cfgLm1[k], 1'b1, 1'b0);
            waitFor(0);
            chkWord(rxData, cfgRx[k]);
            waitFor(1);
            chkFlag(irq, 1'b1);
            waitFor(2);
            chkWord(capWord, cfgWord[k]);
            chkFlag(selOut, ~cfgPol[k]);
            readRx();
            chkFlag(rxValid, 1'b0);
            $display("test master frame %0d done", k);
        end
        send(16'h00F0, 4'h7, 1'b1, 1'b1);
        waitFor(1);
        waitFor(2);
        chkFlag(rxValid, 1'b0);
        chkWord(capWord, 16'h00F0);
        $display("test send without receive done");
        farLen = 5'h10;
        send(16'h00AB, 4'h7, 1'b0, 1'b0);
        waitFor(1);
        repeat (20) @(negedge ref_clk);
        chkFlag(selOut, selActiveHigh);
        send(16'h00CD, 4'h7, 1'b1, 1'b0);
        waitFor(1);
        waitFor(2);
        chkWord(capWord, 16'hABCD);
        $display("test joined frame done");
        enable = 1'b0;
        repeat (4) @(negedge ref_clk);
        masterMode = 1'b0;
        selActiveHigh = 1'b0;
        clkIdleHigh = 1'b0;
        repeat (4) @(negedge ref_clk);
        enable = 1'b1;
        intEnableSet = 3'h7;
        @(negedge ref_clk);
        intEnableSet = 3'h0;
        chkFlag(misoOe, 1'b0);
        fork
            begin
                send(16'h0069, 4'h7, 1'b1, 1'b0);
                chkFlag(wakeReq, 1'b1);
            end
            u_far.frame(16'h0096, 8);
        join
        waitFor(0);
        chkWord(rxData, 16'h0096);
        chkWord(capWord, 16'h0069);
        chkFlag(selChanged, 1'b1);
        chkFlag(irq, 1'b1);
        fork
            send(16'h0011, 4'h7, 1'b1, 1'b0);
            u_far.frame(16'h0022, 8);
        join
        repeat (4) @(negedge ref_clk);
        chkFlag(rxOverrun, 1'b1);
        $display("test slave frames done");
        enable = 1'b0;
        repeat (3) @(negedge ref_clk);
        chkWord({12'h000, rxValid, rxOverrun, selChanged, misoOe}, 16'h0000);
        $display("test disable done");
        finishTest();
    end
endmodule
